// >>> core/clock_mode_pkg.sv
// Package of constants and types for the clock mode control block
`default_nettype none

package clock_mode_pkg;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [3:0] CTRL_ONE_OFFSET   = 4'h0;
    localparam logic [3:0] CTRL_TWO_OFFSET   = 4'h1;
    localparam logic [3:0] CTRL_THREE_OFFSET = 4'h2;
    localparam logic [3:0] STATUS_OFFSET     = 4'h3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    // clock_gen_control_one
    localparam int CSS_HI  = 7;
    localparam int CSS_LO  = 6;
    localparam int REFERENCE_DIVIDER_HI = 5;
    localparam int REFERENCE_DIVIDER_LO = 3;
    localparam int REFS_BIT = 2;
    // clock_gen_control_two
    localparam int LP_BIT    = 3;
    localparam int EREN_BIT  = 1;
    // clock_gen_control_three
    localparam int LOST_LOCK_IRQ_ENABLE_BIT = 7;
    localparam int LOOP_SELECT_BIT  = 6;
    localparam int CME_BIT   = 5;
    localparam int VCO_MULTIPLIER_FIELD_HI   = 3;
    localparam int VCO_MULTIPLIER_FIELD_LO   = 0;
    // clock_gen_status
    localparam int LOST_LOCK_FLAG_BIT  = 7;
    localparam int LOCK_BIT  = 6;
    localparam int LSTAT_BIT = 5;
    localparam int RSTAT_BIT = 4;
    localparam int CST_HI    = 3;
    localparam int CST_LO    = 2;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [1:0] CSS_RESET   = 2'h0;
    localparam logic [2:0] REFERENCE_DIVIDER_RESET  = 3'h0;
    localparam logic       REFS_RESET  = 1'b1;
    localparam logic [3:0] VCO_MULTIPLIER_FIELD_RESET  = 4'h1;
    localparam logic [7:0] DATA_ZERO   = 8'h00;

    localparam logic [1:0] SRC_FLL = 2'h0;
    localparam logic [1:0] SRC_INT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_PLL = 2'h3;

    localparam logic [3:0] VCO_MULTIPLIER_FIELD_LAST_CODE = 4'hA;
    localparam logic [5:0] MULT_STEP      = 6'h04;
    localparam logic [5:0] MULT_MAX       = 6'h28;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    typedef enum logic [1:0] {
        SW_STEADY,
        SW_DRAIN_OLD,
        SW_ENGAGE_NEW
    } switch_state_type;

endpackage

`default_nettype wire

// >>> core/clock_mode_control.sv
// Clock generator mode control: control registers, loop enables and glitch-free output mux
//
// The address map and the plain strobed port are this design's own decisions.
`default_nettype none

// Operation
// RULE_01 - Interrupt when enable and lost-lock flag set
// RULE_02 - Loop select disables the unchosen loop
// RULE_03 - Monitor enable plus clock loss requests reset
// RULE_04 - Software enables monitor only with external reference
// RULE_05 - Software keeps frequency band while monitor on
// RULE_06 - Divider codes 1..10 multiply by four
// RULE_07 - Reserved divider codes; high codes give 40
// RULE_08 - Reset lands in engaged internal mode
// RULE_09 - Engaged internal: output from frequency loop
// RULE_10 - Engaged external needs clock select 00
// RULE_11 - Engaged external: loop locked to external
// RULE_12 - Bypassed internal selected by clock select 01
// RULE_13 - Bypassed internal: output is internal reference
// RULE_14 - Bypassed external selected by clock select 10
// RULE_15 - Bypassed external: output is external reference
// RULE_16 - Debug clock from frequency loop; phase loop off
// RULE_17 - Software may briefly overdrive bypassed external reference
// RULE_18 - Lost-lock flag sticky, write one clears
// RULE_19 - Status reports active source after switch
// RULE_20 - Glitch-free switch, old source until ready
module clock_mode_control
    import clock_mode_pkg::*;
(
    // Clock, reset and enable
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    // Register port
    input  wire reg_req_type       reg_req,
    output var  logic [DATA_W-1:0] rdata,
    // Sampled clock sources
    input  wire logic              int_ref_clk,
    input  wire logic              ext_ref_clk,
    input  wire logic              fll_clk,
    input  wire logic              pll_clk,
    // Source readiness and events
    input  wire logic              fll_locked,
    input  wire logic              pll_locked,
    input  wire logic              ext_ref_ready,
    input  wire logic              lock_lost,
    input  wire logic              ext_clock_lost,
    // Loop controls
    output var  logic              fll_enable,
    output var  logic              pll_enable,
    output var  logic              fll_ref_external,
    output var  logic [2:0]        ref_divider_out,
    output var  logic [5:0]        pll_multiplier,
    // Clocks and requests
    output var  logic              main_output_clock,
    output var  logic              local_debug_clock,
    output var  logic              lost_lock_irq,
    output var  logic              clock_monitor_reset
);

    // ****************************************************************
    // Decoding functions
    // ****************************************************************

    // Divider code to multiplication factor, reserved high codes clamp
    function automatic logic [5:0] vco_factor(input logic [3:0] code);
        logic [5:0] prod;
        prod = 6'({2'h0, code}) * MULT_STEP;
        if (code > VCO_MULTIPLIER_FIELD_LAST_CODE)
            vco_factor = MULT_MAX; // RULE_07
        else if (code == VCO_MULTIPLIER_FIELD_RESET - 4'h1)
            vco_factor = MULT_STEP; // RULE_07
        else
            vco_factor = prod; // RULE_06
    endfunction

    // Sampled level of a source by its status code
    function automatic logic src_level(input logic [1:0] code, input logic [3:0] lv);
        src_level = lv[code];
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [1:0]        clock_source_select_reg;
    logic [2:0]        reference_divider_reg;
    logic              reference_select_reg;
    logic              low_power_bit_reg;
    logic              external_ref_out_enable_reg;
    logic              lost_lock_irq_enable_reg;
    logic              loop_select_reg;
    logic              clock_monitor_enable_reg;
    logic [3:0]        vco_multiplier_field_reg;
    logic              lost_lock_flag_reg;
    logic [1:0]        clock_source_status_reg;
    logic              loop_status_reg;
    logic              ref_status_reg;
    logic [DATA_W-1:0] rdata_reg;
    switch_state_type  sw_state_reg;
    switch_state_type  sw_state_next;
    logic [1:0]        target_src_reg;
    logic              main_clk_reg;
    logic              debug_clk_reg;
    logic              irq_reg;
    logic              cm_reset_reg;
    logic              fll_en_reg;
    logic              pll_en_reg;
    logic              fll_ext_reg;
    logic [2:0]        reference_divider_out_reg;
    logic [5:0]        mult_reg;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic wr_one   = reg_req.wr && (reg_req.addr == CTRL_ONE_OFFSET);
    wire logic wr_two   = reg_req.wr && (reg_req.addr == CTRL_TWO_OFFSET);
    wire logic wr_three = reg_req.wr && (reg_req.addr == CTRL_THREE_OFFSET);
    wire logic wr_stat  = reg_req.wr && (reg_req.addr == STATUS_OFFSET);

    logic [DATA_W-1:0] ctrl_one_val;
    logic [DATA_W-1:0] ctrl_two_val;
    logic [DATA_W-1:0] ctrl_three_val;
    logic [DATA_W-1:0] status_val;
    logic [DATA_W-1:0] read_mux;

    // Register images, reserved bits read zero
    always_comb
    begin
        ctrl_one_val = DATA_ZERO;
        ctrl_one_val[CSS_HI:CSS_LO] = clock_source_select_reg;
        ctrl_one_val[REFERENCE_DIVIDER_HI:REFERENCE_DIVIDER_LO] = reference_divider_reg;
        ctrl_one_val[REFS_BIT] = reference_select_reg;
        ctrl_two_val = DATA_ZERO;
        ctrl_two_val[LP_BIT] = low_power_bit_reg;
        ctrl_two_val[EREN_BIT] = external_ref_out_enable_reg;
        ctrl_three_val = DATA_ZERO;
        ctrl_three_val[LOST_LOCK_IRQ_ENABLE_BIT] = lost_lock_irq_enable_reg;
        ctrl_three_val[LOOP_SELECT_BIT] = loop_select_reg;
        ctrl_three_val[CME_BIT] = clock_monitor_enable_reg;
        ctrl_three_val[VCO_MULTIPLIER_FIELD_HI:VCO_MULTIPLIER_FIELD_LO] = vco_multiplier_field_reg;
        status_val = DATA_ZERO;
        status_val[LOST_LOCK_FLAG_BIT] = lost_lock_flag_reg;
        status_val[LOCK_BIT] = loop_select_reg ? pll_locked : fll_locked;
        status_val[LSTAT_BIT] = loop_status_reg;
        status_val[RSTAT_BIT] = ref_status_reg;
        status_val[CST_HI:CST_LO] = clock_source_status_reg;
    end

    // Read selection, unmapped addresses answer zero
    assign read_mux = (reg_req.addr == CTRL_ONE_OFFSET)   ? ctrl_one_val   :
                      (reg_req.addr == CTRL_TWO_OFFSET)   ? ctrl_two_val   :
                      (reg_req.addr == CTRL_THREE_OFFSET) ? ctrl_three_val :
                      (reg_req.addr == STATUS_OFFSET)     ? status_val     : DATA_ZERO;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    // Engaged modes take the chosen loop, bypassed modes a reference
    wire logic [1:0] engaged_src = loop_select_reg ? SRC_PLL : SRC_FLL; // RULE_02
    wire logic [1:0] req_src =
        (clock_source_select_reg == SRC_FLL) ? engaged_src :     // RULE_09 RULE_11
        (clock_source_select_reg == SRC_INT) ? SRC_INT :         // RULE_13
        (clock_source_select_reg == SRC_EXT) ? SRC_EXT :         // RULE_15
        clock_source_status_reg;
    wire logic [3:0] src_levels = {pll_clk, ext_ref_clk, int_ref_clk, fll_clk};
    wire logic [3:0] src_ready  = {pll_locked, ext_ref_ready, 1'b1, 1'b1};
    wire logic       active_lvl = src_level(clock_source_status_reg, src_levels);
    wire logic       target_lvl = src_level(target_src_reg, src_levels);

    // Low power stops the loops whenever clock select is not 00
    wire logic loops_allowed = !(low_power_bit_reg && (clock_source_select_reg != SRC_FLL));
    wire logic fll_en_next   = !loop_select_reg && loops_allowed; // RULE_02 RULE_16
    wire logic pll_en_next   = loop_select_reg && loops_allowed;  // RULE_02 RULE_16

    // ****************************************************************
    // Control register writes
    // ****************************************************************
    // Reset state is the engaged internal mode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            clock_source_select_reg <= CSS_RESET;    // RULE_08
            reference_divider_reg   <= REFERENCE_DIVIDER_RESET;   // RULE_08
            reference_select_reg    <= REFS_RESET;   // RULE_08
        end
        else if (ce && wr_one)
        begin
            clock_source_select_reg <= reg_req.wdata[CSS_HI:CSS_LO]; // RULE_10 RULE_12 RULE_14
            reference_divider_reg   <= reg_req.wdata[REFERENCE_DIVIDER_HI:REFERENCE_DIVIDER_LO];
            reference_select_reg    <= reg_req.wdata[REFS_BIT];
        end
    end

    // Second control register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            low_power_bit_reg           <= 1'b0;
            external_ref_out_enable_reg <= 1'b0;
        end
        else if (ce && wr_two)
        begin
            low_power_bit_reg           <= reg_req.wdata[LP_BIT];
            external_ref_out_enable_reg <= reg_req.wdata[EREN_BIT];
        end
    end

    // Third control register; monitor use is software's duty
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lost_lock_irq_enable_reg <= 1'b0;
            loop_select_reg          <= 1'b0;        // RULE_08
            clock_monitor_enable_reg <= 1'b0;
            vco_multiplier_field_reg <= VCO_MULTIPLIER_FIELD_RESET;
        end
        else if (ce && wr_three)
        begin
            lost_lock_irq_enable_reg <= reg_req.wdata[LOST_LOCK_IRQ_ENABLE_BIT];
            loop_select_reg          <= reg_req.wdata[LOOP_SELECT_BIT];
            clock_monitor_enable_reg <= reg_req.wdata[CME_BIT];
            vco_multiplier_field_reg <= reg_req.wdata[VCO_MULTIPLIER_FIELD_HI:VCO_MULTIPLIER_FIELD_LO];
        end
    end

    // Sticky flag: a loss in the clearing cycle is kept
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            lost_lock_flag_reg <= 1'b0;                                   // RULE_18
        else if (ce && lock_lost)
            lost_lock_flag_reg <= 1'b1;                                   // RULE_18
        else if (ce && wr_stat && reg_req.wdata[LOST_LOCK_FLAG_BIT])
            lost_lock_flag_reg <= 1'b0;                                   // RULE_18
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdata_reg <= DATA_ZERO;
        else if (ce)
            rdata_reg <= reg_req.rd ? read_mux : DATA_ZERO;
    end

    // ****************************************************************
    // Glitch-free source switch
    // ****************************************************************
    // Old source is left only at its low phase, new one joined at its low
    always_comb
    begin
        sw_state_next = sw_state_reg;
        case (sw_state_reg)
            SW_STEADY:
                if ((req_src != clock_source_status_reg) && src_ready[req_src])
                    sw_state_next = SW_DRAIN_OLD;                         // RULE_20
            SW_DRAIN_OLD:
                if (!active_lvl)
                    sw_state_next = SW_ENGAGE_NEW;                        // RULE_20
            SW_ENGAGE_NEW:
                if (!target_lvl)
                    sw_state_next = SW_STEADY;                            // RULE_20
            default:
                sw_state_next = SW_STEADY;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            sw_state_reg <= SW_STEADY;
        else if (ce)
            sw_state_reg <= sw_state_next;
    end

    // Target is latched so a later write cannot tear a switch
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            target_src_reg <= SRC_FLL;
        else if (ce && sw_state_reg == SW_STEADY)
            target_src_reg <= req_src;
    end

    // Source status moves only once the new source drives the output; loop and reference status follow their bits a cycle late
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            clock_source_status_reg <= SRC_FLL;
            loop_status_reg         <= 1'b0;
            ref_status_reg          <= REFS_RESET;
        end
        else if (ce)
        begin
            if (sw_state_reg == SW_ENGAGE_NEW && !target_lvl)
                clock_source_status_reg <= target_src_reg;                // RULE_19
            loop_status_reg <= loop_select_reg;                           // RULE_19
            ref_status_reg  <= reference_select_reg;                      // RULE_19
        end
    end

    // Output held low between the two sources
    wire logic main_clk_next = (sw_state_reg == SW_ENGAGE_NEW) ? 1'b0 :
                               (sw_state_reg == SW_DRAIN_OLD && !active_lvl) ? 1'b0 : active_lvl;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            main_clk_reg  <= 1'b0;
            debug_clk_reg <= 1'b0;
        end
        else if (ce)
        begin
            main_clk_reg  <= main_clk_next;                               // RULE_09 RULE_13 RULE_15
            debug_clk_reg <= fll_clk && fll_en_reg;                       // RULE_16
        end
    end

    // ****************************************************************
    // Loop controls and requests
    // ****************************************************************
    // Frequency loop follows the chosen reference even when bypassed
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fll_en_reg   <= 1'b1;
            pll_en_reg   <= 1'b0;
            fll_ext_reg  <= 1'b0;
            reference_divider_out_reg <= REFERENCE_DIVIDER_RESET;
            mult_reg     <= MULT_STEP;
        end
        else if (ce)
        begin
            fll_en_reg   <= fll_en_next;                                  // RULE_02 RULE_16
            pll_en_reg   <= pll_en_next;                                  // RULE_02 RULE_16
            fll_ext_reg  <= !reference_select_reg;                        // RULE_11 RULE_15
            reference_divider_out_reg <= reference_divider_reg;
            mult_reg     <= vco_factor(vco_multiplier_field_reg);         // RULE_06 RULE_07
        end
    end

    // Requests are levels while their cause stands
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irq_reg      <= 1'b0;
            cm_reset_reg <= 1'b0;
        end
        else if (ce)
        begin
            irq_reg      <= lost_lock_irq_enable_reg && lost_lock_flag_reg; // RULE_01
            cm_reset_reg <= clock_monitor_enable_reg && ext_clock_lost;   // RULE_03
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata               = rdata_reg;
    assign fll_enable          = fll_en_reg;
    assign pll_enable          = pll_en_reg;
    assign fll_ref_external    = fll_ext_reg;
    assign ref_divider_out     = reference_divider_out_reg;
    assign pll_multiplier      = mult_reg;
    assign main_output_clock   = main_clk_reg;
    assign local_debug_clock   = debug_clk_reg;
    assign lost_lock_irq       = irq_reg;
    assign clock_monitor_reset = cm_reset_reg;

endmodule

`default_nettype wire

// >>> core/placeholder_unused.sv
// Empty compilation unit kept minimal
`default_nettype none
`default_nettype wire

// >>> test/clock_mode_props.sv
// Port-level checker for the clock mode control block
`default_nettype none

module clock_mode_props
    import clock_mode_pkg::*;
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // Register port
    input wire reg_req_type       reg_req,
    // Causes
    input wire logic              fll_clk,
    input wire logic              lock_lost,
    input wire logic              ext_clock_lost,
    // Effects
    input wire logic              fll_enable,
    input wire logic              pll_enable,
    input wire logic              fll_ref_external,
    input wire logic [5:0]        pll_multiplier,
    input wire logic              local_debug_clock,
    input wire logic              lost_lock_irq,
    input wire logic              clock_monitor_reset
);
    // One domain, so clock and reset are given once
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_loops_exclusive: assert property (!(fll_enable && pll_enable))
        else $error("both loops enabled");
    a_loop_en_cause: assert property (($changed(fll_enable) || $changed(pll_enable)) |-> $past(reg_req.wr, 2))
        else $error("loop enable moved without a write");
    a_debug_from_fll: assert property (!$past(rst) |-> local_debug_clock == ($past(fll_clk) && $past(fll_enable)))
        else $error("debug clock not from frequency loop");
    a_monitor_cause: assert property (clock_monitor_reset |-> $past(ext_clock_lost))
        else $error("monitor reset without clock loss");
    a_mult_range: assert property (pll_multiplier[1:0] == 2'h0 && pll_multiplier inside {[6'h04:6'h28]})
        else $error("multiplier outside 4 to 40");
    a_mult_after_wr: assert property ($changed(pll_multiplier) |->
        $past(reg_req.wr, 2) && $past(reg_req.addr, 2) == CTRL_THREE_OFFSET)
        else $error("multiplier moved without a write");
    a_irq_rise: assert property ($rose(lost_lock_irq) |-> $past(lock_lost, 2) || $past(reg_req.wr, 2))
        else $error("interrupt rose without cause");
    a_irq_fall: assert property ($fell(lost_lock_irq) |-> $past(reg_req.wr, 2))
        else $error("interrupt fell without a write");
    a_ref_ext_cause: assert property ($changed(fll_ref_external) |->
        $past(reg_req.wr, 2) && $past(reg_req.addr, 2) == CTRL_ONE_OFFSET)
        else $error("reference choice moved without a write");
endmodule

bind clock_mode_control clock_mode_props u_props (.clk_sys, .rst, .reg_req, .fll_clk, .lock_lost,
    .ext_clock_lost, .fll_enable, .pll_enable, .fll_ref_external, .pll_multiplier, .local_debug_clock,
    .lost_lock_irq, .clock_monitor_reset);

`default_nettype wire

// >>> test/testbench.sv
// Self-checking testbench for the clock mode control block
`default_nettype none

module testbench
    import clock_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys, rst, ce, int_ref_clk, ext_ref_clk, fll_clk, pll_clk;
    logic        fll_locked, pll_locked, ext_ref_ready, lock_lost, ext_clock_lost;
    logic        fll_enable, pll_enable, fll_ref_external, main_output_clock, local_debug_clock;
    logic        lost_lock_irq, clock_monitor_reset;
    reg_req_type reg_req;
    logic [7:0]  rdata, v;
    logic [2:0]  ref_divider_out;
    logic [5:0]  pll_multiplier;
    logic [3:0]  phase;
    int          bad_count, num_checks;

    clock_mode_control dut (.clk_sys, .rst, .ce, .reg_req, .rdata, .int_ref_clk, .ext_ref_clk, .fll_clk,
        .pll_clk, .fll_locked, .pll_locked, .ext_ref_ready, .lock_lost, .ext_clock_lost, .fll_enable,
        .pll_enable, .fll_ref_external, .ref_divider_out, .pll_multiplier, .main_output_clock,
        .local_debug_clock, .lost_lock_irq, .clock_monitor_reset);

    // ****
    // Clock and source waveforms
    // ****
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Sources at different rates so a wrong mux choice shows
    always @(posedge clk_sys)
    begin
        phase       <= phase + 4'h1;
        fll_clk     <= ~fll_clk;
        int_ref_clk <= phase[1];
        ext_ref_clk <= phase[0] ^ phase[2];
        pll_clk     <= phase[3];
    end

    // ****
    // Tasks
    // ****
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Each drive made after cyc lands 1 ns after an edge, outputs settled by then
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_req <= '{a, d, 1'b1, 1'b0};
        cyc(1);
        reg_req <= '{a, d, 1'b0, 1'b0};
        cyc(1);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_req <= '{a, DATA_ZERO, 1'b0, 1'b1};
        cyc(1);
        d = rdata;
        reg_req <= '{a, DATA_ZERO, 1'b0, 1'b0};
        cyc(1);
    endtask

    // Output is the chosen source one cycle late
    task automatic track(input logic [1:0] s);
        logic p;
        repeat (8)
        begin
            p = s == SRC_INT ? int_ref_clk : s == SRC_EXT ? ext_ref_clk : fll_clk;
            cyc(1);
            chk("main_clk", main_output_clock, p);
        end
    endtask

    // Bounded poll of the status until the switch lands
    task automatic mode(input logic [7:0] c1, input logic [1:0] s);
        wr(CTRL_ONE_OFFSET, c1);
        v = {4'h0, ~s, 2'h0};
        for (int i = 0; i < 40 && v[3:2] !== s; i++)
            rd(STATUS_OFFSET, v);
        chk("src_status", v[3:2], s);
        if (v[3:2] !== s)
            wrap_up();
        track(s);
    endtask

    // Hang guard
    initial
    begin
        #5000000;
        bad_count++;
        wrap_up();
    end

    // ****
    // Main sequence
    // ****
    initial
    begin
        {rst, ce, fll_locked} = 3'h7;
        {int_ref_clk, ext_ref_clk, fll_clk, pll_clk, pll_locked, ext_ref_ready, lock_lost, ext_clock_lost} = 8'h00;
        {reg_req, phase, bad_count, num_checks} = '0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        cyc(1);
        rd(CTRL_THREE_OFFSET, v);
        chk("ctrl_three", v, 8'h01);
        rd(CTRL_ONE_OFFSET, v);
        chk("ctrl_one", v, 8'h04);
        rd(4'hF, v);
        chk("unmapped", v, DATA_ZERO);
        chk("pll_en", pll_enable, 8'h00);
        // Every divider code, reserved ones included
        for (int i = 0; i < 16; i++)
        begin
            wr(CTRL_THREE_OFFSET, 8'(i));
            chk("mult", pll_multiplier, i == 0 ? 8'h04 : i > 10 ? 8'h28 : 8'(4 * i));
        end
        wr(CTRL_THREE_OFFSET, 8'h41);
        chk("pll_en", pll_enable, 8'h01);
        chk("fll_en", fll_enable, 8'h00);
        wr(CTRL_THREE_OFFSET, 8'h01);
        chk("fll_en", fll_enable, 8'h01);
        repeat (4)
        begin
            v[0] = fll_clk;
            cyc(1);
            chk("dbg_clk", local_debug_clock, v[0]);
        end
        // Sticky flag, masked then unmasked, write-zero ignored
        lock_lost <= 1'b1;
        cyc(1);
        lock_lost <= 1'b0;
        cyc(3);
        chk("irq_masked", lost_lock_irq, 8'h00);
        wr(STATUS_OFFSET, 8'h00);
        rd(STATUS_OFFSET, v);
        chk("flag", v[7], 8'h01);
        wr(CTRL_THREE_OFFSET, 8'h81);
        chk("irq_on", lost_lock_irq, 8'h01);
        wr(STATUS_OFFSET, 8'h80);
        chk("irq_off", lost_lock_irq, 8'h00);
        // Clock monitor, enabled only with the reference output on
        ext_clock_lost <= 1'b1;
        cyc(2);
        chk("mon_off", clock_monitor_reset, 8'h00);
        wr(CTRL_TWO_OFFSET, 8'h02);
        wr(CTRL_THREE_OFFSET, 8'h21);
        chk("mon_on", clock_monitor_reset, 8'h01);
        ext_clock_lost <= 1'b0;
        wr(CTRL_THREE_OFFSET, 8'h01);
        // Mode walk: bypassed internal, stalled then bypassed external
        mode(8'h44, SRC_INT);
        // Low power while bypassed stops the frequency loop
        wr(CTRL_TWO_OFFSET, 8'h0A);
        chk("lp_fll_off", fll_enable, 8'h00);
        wr(CTRL_TWO_OFFSET, 8'h02);
        chk("lp_fll_on", fll_enable, 8'h01);
        wr(CTRL_ONE_OFFSET, 8'h98);
        cyc(20);
        rd(STATUS_OFFSET, v);
        chk("src_held", v[3:2], SRC_INT);
        track(SRC_INT);
        ext_ref_ready <= 1'b1;
        mode(8'h98, SRC_EXT);
        chk("ref_ext", fll_ref_external, 8'h01);
        chk("fll_run", fll_enable, 8'h01);
        mode(8'h18, SRC_FLL);
        chk("reference_divider", ref_divider_out, 8'h03);
        mode(8'h04, SRC_FLL);
        chk("ref_int", fll_ref_external, 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
